// *** verilog/lsf_dec_pkg.sv ***
/*
  Constants, tables and carrier types of the spectral index decoder.
  Assumes one clock domain and a parser that hands over one whole frame field at a time.
*/
`default_nettype none
package lsf_dec_pkg;
  localparam int DIM      = 16;
  localparam int SUBDIM   = 8;
  localparam int FRAME_W  = 40;
  localparam int IDX_W    = 29;
  localparam int SUB_W    = 15;
  localparam int LSF_W    = 16;
  localparam int STG_W    = 5;
  localparam int NSUB_LO  = 4;
  localparam int NSUB_HI  = 5;
  // Index count of one subvector, used to split the combined lattice index.
  localparam logic [SUB_W-1:0] SUB_COUNT = 15'h4120;
  localparam logic [1:0][SUB_W-1:0] SCALE_OFS = {15'h2090, 15'h0000};
  localparam logic [1:0][7:0] SCALE_MUL = {8'h02, 8'h01};
  localparam logic [3:0][12:0] LEAD_OFS = {13'h0650, 13'h0110, 13'h0100, 13'h0000};
  localparam logic [3:0][12:0] LEAD_PERM = {13'h0348, 13'h00A8, 13'h0008, 13'h0001};
  localparam logic [3:0][2:0] LEAD_NDIST = {3'h4, 3'h3, 3'h2, 3'h1};
  // Per class, entry m is the m-th distinct value and its number of occurrences.
  localparam logic [3:0][3:0][7:0] LEAD_VAL = {{8'h00, 8'h01, 8'h02, 8'h03},
                                               {8'h00, 8'h00, 8'h01, 8'h02},
                                               {8'h00, 8'h00, 8'h00, 8'h02},
                                               {8'h00, 8'h00, 8'h00, 8'h01}};
  localparam logic [3:0][3:0][3:0] LEAD_CNT = {{4'h4, 4'h2, 4'h1, 4'h1},
                                               {4'h0, 4'h5, 4'h2, 4'h1},
                                               {4'h0, 4'h0, 4'h7, 4'h1},
                                               {4'h0, 4'h0, 4'h0, 4'h8}};
  // Stage widths per coding mode: [mode][stage].
  localparam logic [1:0][1:0][2:0] STAGE_W = {{3'h4, 3'h5}, {3'h3, 3'h4}};

  typedef enum logic [1:0] {PRED_SAFETY = 2'h0, PRED_AR_SW = 2'h1, PRED_MA_SW = 2'h2} pred_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_SPLIT = 3'b001, ST_OFFS = 3'b011, ST_LEVEL = 3'b010,
    ST_SEARCH = 3'b110, ST_SIGN = 3'b111, ST_SUM = 3'b101, ST_OUT = 3'b100
  } state_t;

  typedef struct packed {
    logic               valid;
    logic [FRAME_W-1:0] bits;
    logic               mode;
    pred_t              pred;
    logic               hi_rate;
  } frame_t;

  typedef struct packed {
    logic                      valid;
    logic                      last;
    logic [2:0]                sub_idx;
    logic [DIM-1:0][LSF_W-1:0] lsf;
  } lsf_vec_t;

  // Pascal triangle: coefficient lookups reduce to adders folded at build time.
  function automatic logic [12:0] binom(input logic [3:0] n, input logic [3:0] k);
    logic [8:0][8:0][12:0] c;
    c = '0;
    for (int a = 0; a <= 8; a++) begin
      c[a][0] = 13'h0001;
      for (int b = 1; b <= a; b++) begin
        c[a][b] = c[a-1][b-1] + c[a-1][b];
      end
    end
    return (n > 4'h8 || k > n) ? 13'h0000 : c[n][k];
  endfunction

  // Trained tables are loaded per product; these defaults are arbitrary fillers.
  function automatic logic [LSF_W-1:0] stage_cv(input int s, input logic [4:0] idx, input int i);
    return LSF_W'((((int'(idx) * 5 + i * 3 + s * 7) & 15) - 8) * 16);
  endfunction
  function automatic logic [7:0] std_dev(input logic mode, input int i);
    return 8'(16 + i + (mode ? 4 : 0));
  endfunction
  function automatic logic [LSF_W-1:0] mean_lsf(input logic mode, input int i);
    return LSF_W'((i + 1) * 192 + (mode ? 16 : 0));
  endfunction
endpackage
`default_nettype wire

// *** verilog/lsf_index_decoder.sv ***
/*
  Spectral parameter index decoder: parses one frame field, rebuilds the lattice
  codevector, adds stages, mean and prediction, and emits one vector per subframe.
  Assumes the parser holds frame_in stable only for the cycle it is valid and
  offers a new frame only while busy is low.
*/
`default_nettype none
`timescale 1ns/1ps
// Function
// - Switched schemes: first bit selects safety net or prediction
// - Read stage groups, remaining bits are lattice
// - Split lattice index by quotient and remainder
// - Remove scale then leader offsets
// - Divide by permutation count: sign, permutation
// - Single-valued class fills all eight components
// - Two values: prefill second, place first
// - Binomial search for each position
// - Insert values only after all positions known
// - Three values: split by binomial, place twice
// - Four values: split twice, place three times
// - Scale, weight by deviation, add all stages
// - Safety net adds the mode mean
// - AR adds previous frame vector and mean
// - MA adds previous error, keeps error state
// - Four or five interpolated subframe vectors
module lsf_index_decoder
  import lsf_dec_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     resetn,
  input  wire frame_t   frame_in,
  output var  logic     busy,
  output var  lsf_vec_t vec_out
);

  typedef struct packed {
    state_t                    st;
    logic                      busy;
    logic                      mode;
    pred_t                     pred;
    logic                      hi;
    logic                      safety;
    logic [1:0][STG_W-1:0]     stg;
    logic [IDX_W-1:0]          lat_i;
    logic                      sub;
    logic [1:0][SUB_W-1:0]     sidx;
    logic                      scale;
    logic [1:0]                lead;
    logic [8:0]                sgn;
    logic [12:0]               rem;
    logic [1:0]                lvl;
    logic [12:0]               srch;
    logic [3:0]                len;
    logic [3:0]                kk;
    logic [3:0]                base;
    logic [7:0]                mask;
    logic [SUBDIM-1:0][7:0]    x;
    logic [DIM-1:0][LSF_W-1:0] lat;
    logic [DIM-1:0][LSF_W-1:0] old;
    logic [DIM-1:0][LSF_W-1:0] prev;
    logic [DIM-1:0][LSF_W-1:0] err;
    logic [2:0]                osub;
    lsf_vec_t                  out;
  } dec_state_t;

  logic [1:0] rst_sync_q;
  logic       rst_n;
  dec_state_t q;
  dec_state_t d;

  // The reset is released through two flops so its removal meets timing.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Number of positions spanned from class value m up to the last one.
  function automatic logic [3:0] span(input logic [1:0] lead, input logic [1:0] m);
    logic [3:0] s;
    s = 4'h0;
    for (int t = 0; t < 4; t++) begin
      if (t >= int'(m)) begin
        s = s + LEAD_CNT[lead][t];
      end
    end
    return s;
  endfunction

  function automatic logic [LSF_W-1:0] interp(input logic [LSF_W-1:0] a, input logic [LSF_W-1:0] b,
                                              input logic [2:0] s, input logic hi);
    int n;
    int r;
    n = hi ? NSUB_HI : NSUB_LO;
    r = (int'($signed(a)) * (n - 1 - int'(s)) + int'($signed(b)) * (int'(s) + 1)) / n;
    return LSF_W'(r);
  endfunction

  always_comb begin
    logic [FRAME_W-1:0] tmp;
    logic [SUB_W-1:0]   v;
    logic [12:0]        c;
    logic [3:0]         n;
    logic [3:0]         ptr;
    logic [3:0]         t;
    logic [7:0]         val;
    logic [LSF_W-1:0]   s;
    logic [LSF_W-1:0]   pred_term;
    tmp = '0;
    v = '0;
    c = '0;
    n = '0;
    ptr = '0;
    t = '0;
    val = '0;
    s = '0;
    pred_term = '0;
    d = q;
    d.out.valid = 1'b0;
    d.out.last = 1'b0;
    unique case (q.st)
      ST_IDLE: begin
        if (frame_in.valid) begin
          d.mode = frame_in.mode;
          d.pred = frame_in.pred;
          d.hi = frame_in.hi_rate;
          d.safety = (frame_in.pred == PRED_SAFETY) ? 1'b1 : frame_in.bits[FRAME_W-1];
          tmp = (frame_in.pred == PRED_SAFETY) ? frame_in.bits : (frame_in.bits << 1);
          for (int k = 0; k < 2; k++) begin
            d.stg[k] = tmp[FRAME_W-1 -: STG_W] >> (3'(STG_W) - STAGE_W[frame_in.mode][k]);
            tmp = tmp << STAGE_W[frame_in.mode][k];
          end
          d.lat_i = tmp[FRAME_W-1 -: IDX_W];
          d.st = ST_SPLIT;
        end
      end
      ST_SPLIT: begin
        d.sidx[0] = SUB_W'(q.lat_i / IDX_W'(SUB_COUNT));
        d.sidx[1] = SUB_W'(q.lat_i % IDX_W'(SUB_COUNT));
        d.sub = 1'b0;
        d.st = ST_OFFS;
      end
      ST_OFFS: begin
        v = q.sidx[q.sub];
        d.scale = (v >= SCALE_OFS[1]);
        v = v - SCALE_OFS[d.scale];
        d.lead = 2'h0;
        for (int k = 1; k < 4; k++) begin
          if (v >= SUB_W'(LEAD_OFS[k])) begin
            d.lead = 2'(k);
          end
        end
        v = v - SUB_W'(LEAD_OFS[d.lead]);
        d.sgn = 9'(v / SUB_W'(LEAD_PERM[d.lead]));
        d.rem = 13'(v % SUB_W'(LEAD_PERM[d.lead]));
        n = LEAD_CNT[d.lead][LEAD_NDIST[d.lead] - 3'h1];
        val = LEAD_VAL[d.lead][LEAD_NDIST[d.lead] - 3'h1];
        for (int j = 0; j < SUBDIM; j++) begin
          d.x[j] = (4'(j) < n) ? val : 8'h00;
        end
        d.lvl = 2'(LEAD_NDIST[d.lead] - 3'h2);
        d.st = (LEAD_NDIST[d.lead] == 3'h1) ? ST_SIGN : ST_LEVEL;
      end
      ST_LEVEL: begin
        n = span(q.lead, q.lvl);
        c = binom(n, LEAD_CNT[q.lead][q.lvl]);
        if (q.lvl != 2'h0) begin
          d.srch = q.rem % c;
          d.rem = q.rem / c;
        end else begin
          d.srch = q.rem;
        end
        d.len = n;
        d.kk = LEAD_CNT[q.lead][q.lvl];
        d.base = 4'h0;
        d.mask = 8'h00;
        d.st = ST_SEARCH;
      end
      ST_SEARCH: begin
        if (q.kk == 4'h0) begin
          // insert once every position is known
          n = span(q.lead, q.lvl);
          val = LEAD_VAL[q.lead][q.lvl];
          ptr = 4'h0;
          for (int j = 0; j < SUBDIM; j++) begin
            if (4'(j) >= n) begin
              d.x[j] = 8'h00;
            end else if (q.mask[j]) begin
              d.x[j] = val;
            end else begin
              d.x[j] = q.x[ptr[2:0]];
              ptr = ptr + 4'h1;
            end
          end
          d.lvl = q.lvl - 2'h1;
          d.st = (q.lvl == 2'h0) ? ST_SIGN : ST_LEVEL;
        end else begin
          c = binom(q.len - 4'h1, q.kk - 4'h1);
          if (q.srch < c) begin
            d.mask[q.base[2:0]] = 1'b1;
            d.kk = q.kk - 4'h1;
          end else begin
            d.srch = q.srch - c;
          end
          d.base = q.base + 4'h1;
          d.len = q.len - 4'h1;
        end
      end
      ST_SIGN: begin
        t = 4'h0;
        for (int j = 0; j < SUBDIM; j++) begin
          val = q.x[j];
          if (val != 8'h00) begin
            val = q.sgn[t] ? -val : val;
            t = t + 4'h1;
          end
          d.lat[int'(q.sub) * SUBDIM + j] = LSF_W'($signed(val) * $signed({8'h00, SCALE_MUL[q.scale]})
                                  * $signed({8'h00, std_dev(q.mode, int'(q.sub) * SUBDIM + j)}));
        end
        d.sub = 1'b1;
        d.st = q.sub ? ST_SUM : ST_OFFS;
      end
      ST_SUM: begin
        for (int i = 0; i < DIM; i++) begin
          s = stage_cv(0, q.stg[0], i) + stage_cv(1, q.stg[1], i) + q.lat[i];
          if (q.safety) begin
            pred_term = '0;
          end else if (q.pred == PRED_AR_SW) begin
            pred_term = q.prev[i];
          end else begin
            pred_term = q.err[i];
          end
          d.old[i] = q.prev[i];
          d.prev[i] = s + mean_lsf(q.mode, i) + pred_term;
          // error state carried to the next frame
          if (q.pred == PRED_MA_SW) begin
            d.err[i] = s;
          end
        end
        d.osub = 3'h0;
        d.st = ST_OUT;
      end
      ST_OUT: begin
        d.out.valid = 1'b1;
        d.out.sub_idx = q.osub;
        d.out.last = (q.osub == 3'((q.hi ? NSUB_HI : NSUB_LO) - 1));
        for (int i = 0; i < DIM; i++) begin
          d.out.lsf[i] = interp(q.old[i], q.prev[i], q.osub, q.hi);
        end
        d.osub = q.osub + 3'h1;
        d.st = d.out.last ? ST_IDLE : ST_OUT;
      end
    endcase
    d.busy = (d.st != ST_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign vec_out = q.out;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sel_scheme_a: assert property (
    (q.st == ST_IDLE && frame_in.valid && frame_in.pred != PRED_SAFETY)
      |=> q.safety == $past(frame_in.bits[FRAME_W-1]))
    else $error("scheme selector not taken from first bit");
  stage_width_a: assert property (
    (q.st == ST_SPLIT) |-> (q.stg[1] >> STAGE_W[q.mode][1]) == '0)
    else $error("stage index wider than its group");
  split_idx_a: assert property (
    (q.st == ST_SPLIT) |=> q.sidx[1] < SUB_COUNT
      && IDX_W'(q.sidx[0]) * IDX_W'(SUB_COUNT) + IDX_W'(q.sidx[1]) == $past(q.lat_i))
    else $error("lattice index split wrong");
  offset_rm_a: assert property (
    (q.st == ST_OFFS) |=> SCALE_OFS[q.scale] + SUB_W'(LEAD_OFS[q.lead]) <= $past(q.sidx[q.sub]))
    else $error("offset above subvector index");
  perm_idx_a: assert property (
    (q.st == ST_OFFS) |=> q.rem < LEAD_PERM[q.lead])
    else $error("permutation index out of range");
  single_val_a: assert property (
    (q.st == ST_SIGN && LEAD_NDIST[q.lead] == 3'h1) |-> q.x == {SUBDIM{LEAD_VAL[q.lead][0]}})
    else $error("single value class not uniform");
  search_bnd_a: assert property (
    (q.st == ST_SEARCH && q.kk != 4'h0) |-> q.srch < binom(q.len, q.kk))
    else $error("binomial search index exceeds range");
  place_cnt_a: assert property (
    (q.st == ST_SEARCH && q.kk == 4'h0) |-> $countones(q.mask) == int'(LEAD_CNT[q.lead][q.lvl]))
    else $error("placed before all positions found");
  sub_lo_a: assert property (
    (q.st == ST_SUM && !q.hi) |=> ##1 q.out.valid [*4] ##1 !q.out.valid)
    else $error("low rate frame not four subframes");
  sub_hi_a: assert property (
    (q.st == ST_SUM && q.hi) |=> ##1 q.out.valid [*5] ##1 !q.out.valid)
    else $error("high rate frame not five subframes");

  four_val_c: cover property (q.st == ST_LEVEL && q.lvl == 2'h2);
  single_c: cover property (q.st == ST_SIGN && LEAD_NDIST[q.lead] == 3'h1);
  ar_hi_c: cover property (q.st == ST_SUM && !q.safety && q.pred == PRED_AR_SW && q.hi);
  ma_c: cover property (q.st == ST_SUM && !q.safety && q.pred == PRED_MA_SW);

endmodule // lsf_index_decoder
`default_nettype wire

// *** tb/lsf_frame_source.sv ***
/*
  Parser model: offers one frame field per request, one cycle long.
  Assumes the bench raises offer for one cycle and holds payload meanwhile.
*/
`timescale 1ns/1ps
`default_nettype none
module lsf_frame_source
  import lsf_dec_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   offer,
  input  wire logic   rude,
  input  wire frame_t payload,
  input  wire logic   busy,
  output var  frame_t frame_in
);
  logic pend_q;
  initial begin
    pend_q = 1'b0;
    frame_in = '0;
  end
  always @(posedge clk) begin
    // A rude offer ignores busy, as a faulty parser would.
    if ((offer || pend_q) && (rude || (!busy && !frame_in.valid))) begin
      frame_in <= payload;
      frame_in.valid <= 1'b1;
      pend_q <= 1'b0;
    end else begin
      // Between frames the lines carry junk so a stale field cannot pass unseen.
      frame_in.valid <= 1'b0;
      frame_in.bits <= ~frame_in.bits;
      pend_q <= pend_q || offer;
    end
  end
endmodule // lsf_frame_source
`default_nettype wire

// *** tb/lsf_index_decoder_tb.sv ***
/*
  Self-checking bench of the spectral index decoder behind a parser model.
  Assumes the package filler tables for stage codebooks, deviations and means.
*/
`timescale 1ns/1ps
`default_nettype none
module lsf_index_decoder_tb
  import lsf_dec_pkg::*;
;
  logic     clk;
  logic     resetn;
  logic     offer;
  logic     rude;
  frame_t   payload;
  frame_t   frame_in;
  logic     busy;
  lsf_vec_t vec_out;
  int       fail_count;
  int       checks;
  int       prev_lsf[16];
  int       err_lsf[16];

  lsf_frame_source src (.clk(clk), .offer(offer), .rude(rude), .payload(payload),
                        .busy(busy), .frame_in(frame_in));
  lsf_index_decoder DUT (.clk(clk), .resetn(resetn), .frame_in(frame_in), .busy(busy),
                         .vec_out(vec_out));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk_val(input logic [15:0] got, input logic [15:0] want, input string what);
    checks++;
    if (got !== want) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, want);
    end
  endtask

  task automatic chk_lsf(input logic [DIM-1:0][LSF_W-1:0] got,
                         input logic [DIM-1:0][LSF_W-1:0] want);
    checks++;
    if (got !== want) begin
      fail_count++;
      $display("CHECK FAILED at %0t: vector got %h expected %h", $time, got, want);
    end
  endtask

  function automatic int cv(input int s, input int idx, input int i);
    return (((idx * 5 + i * 3 + s * 7) & 15) - 8) * 16;
  endfunction

  // Sends one frame and judges the last vector, which equals the new frame vector exactly.
  task automatic run_frame(input logic mode, input pred_t pr, input logic sel, input logic hi,
                           input int a, input int b, input int i1, input int i2,
                           input int m1, input int m2, input int x[16], input logic junk);
    logic [63:0]               v;
    logic [DIM-1:0][LSF_W-1:0] exv;
    int                        n;
    int                        k;
    int                        nsub;
    int                        want[16];
    int                        stg[16];
    n = (pr == PRED_SAFETY) ? 29 : 30;
    n = n + (mode ? 9 : 7);
    v = (pr == PRED_SAFETY) ? 64'h0 : 64'(sel);
    v = (v << (mode ? 5 : 4)) | 64'(a);
    v = (v << (mode ? 4 : 3)) | 64'(b);
    v = (v << 29) | 64'(i1 * int'(SUB_COUNT) + i2);
    nsub = hi ? 5 : 4;
    for (int i = 0; i < 16; i++) begin
      stg[i] = cv(0, a, i) + cv(1, b, i) + x[i] * (i < 8 ? m1 : m2) * (16 + i + (mode ? 4 : 0));
      want[i] = stg[i] + (i + 1) * 192 + (mode ? 16 : 0);
      if (!sel && pr == PRED_AR_SW) want[i] += prev_lsf[i];
      if (!sel && pr == PRED_MA_SW) want[i] += err_lsf[i];
      exv[i] = 16'(want[i]);
    end
    @(posedge clk);
    payload <= '{valid: 1'b1, bits: 40'(v << (40 - n)), mode: mode, pred: pr, hi_rate: hi};
    offer <= 1'b1;
    k = 0;
    for (int c = 0; c < 300; c++) begin
      @(posedge clk);
      offer <= junk && c == 5;
      rude <= junk && c == 5;
      #1;
      if (junk && c == 4) chk_val(16'(busy), 16'h0001, "busy in frame");
      if (vec_out.valid === 1'b1) begin
        chk_val(16'(vec_out.sub_idx), 16'(k), "subframe number");
        k++;
        chk_val(16'(vec_out.last), 16'(k == nsub), "last flag");
        if (k == nsub) begin
          chk_lsf(vec_out.lsf, exv);
          chk_val(16'(busy), 16'h0000, "busy with last");
          break;
        end
      end
    end
    chk_val(16'(k), 16'(nsub), "vector count");
    if (junk) begin
      k = 0;
      repeat (100) begin
        @(posedge clk);
        #1;
        if (vec_out.valid === 1'b1) k++;
      end
      chk_val(16'(k), 16'h0000, "vectors of refused frame");
    end
    prev_lsf = want;
    if (!sel && pr == PRED_MA_SW) err_lsf = stg;
  endtask

  task automatic t_safety_only();
    run_frame(1'b0, PRED_SAFETY, 1'b0, 1'b0, 9, 5, 0, 8605, 1, 2,
      '{1, 1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0, -2, 0, 0}, 1'b0);
  endtask

  task automatic t_switched_safety();
    run_frame(1'b1, PRED_AR_SW, 1'b1, 1'b1, 21, 11, 335, 1616, 1, 1,
      '{1, 1, 0, 2, 0, 0, 0, 0, 3, 2, 1, 1, 0, 0, 0, 0}, 1'b0);
  endtask

  task automatic t_ar();
    run_frame(1'b1, PRED_AR_SW, 1'b0, 1'b0, 3, 15, 259, 0, 1, 1,
      '{0, 0, 0, 2, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1}, 1'b0);
  endtask

  task automatic t_ma();
    run_frame(1'b0, PRED_MA_SW, 1'b0, 1'b1, 1, 2, 0, 263, 1, 1,
      '{1, 1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0, 2}, 1'b0);
    run_frame(1'b0, PRED_MA_SW, 1'b0, 1'b1, 14, 6, 264, 0, 1, 1,
      '{-2, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1}, 1'b1);
  endtask

  task automatic print_verdict();
    $display("checks %0d, failures %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The frames need well under a thousand cycles; this bound only cuts a hang.
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    resetn = 1'b0;
    offer = 1'b0;
    rude = 1'b0;
    payload = '0;
    fail_count = 0;
    checks = 0;
    prev_lsf = '{default: 0};
    err_lsf = '{default: 0};
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk_val(16'(busy), 16'h0000, "busy after reset");
    chk_val(16'(vec_out.valid), 16'h0000, "valid after reset");
    t_safety_only();
    t_switched_safety();
    t_ar();
    t_ma();
    print_verdict();
  end
endmodule // lsf_index_decoder_tb
`default_nettype wire
